// file: hdl/smi_mem_if.v
// Shared memory interface: decode, cycle timing, refresh, arbitration
// Functional notes
// R1: DRAM space up to 16 Mbyte, SRAM space up to 1 Mbyte.
// R2: Every memory location is one 16-bit word.
// R3: Each memory cycle lasts p periods of the crystal clock; the sequencer takes p per phase, 2p+1 in all.
// R4: SRAM uses 19 address lines and 8 byte chip enables.
// R5: 128Kx8 SRAM enable index is address bits 19, 18, 0.
// R6: 128Kx8 SRAM address lines 0-16 carry processor bits 1-17.
// R7: 512K SRAM address carries bits 1-19; enable follows bit 0.
// R8: DRAM uses 11 muxed lines, 4 row and 2 column strobes.
// R9: Row-strobe-only refresh at a programmable rate.
// R10: 256K DRAM: row strobe from bits 20,19; 9-bit row/column.
// R11: 1M DRAM: row strobe from bits 22,20; 10-bit row/column.
// R12: 4M DRAM: bit 23 picks row strobe; 11-bit row/column.
// R13: Priority: rx DMA, processor, tx DMA, interrupts, refresh.
// R14: When done, pass token by a 30 ns pulse on token output.
// R15: Processor uses second select for memory, first for registers.
// R16: Start cycles only while holding the token; release before passing.
// R17: Unused enables and strobes stay high outside their cycle.
`timescale 1ns/1ps
`default_nettype none
`include "smi_defs.vh"
module smi_mem_if #(
    parameter AW = 24,
    parameter CLK_NS = `SMI_CLK_PERIOD_NS
) (
    input wire ref_clk,
    input wire reset,
    input wire register_select,
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire shared_memory_select,
    input wire [AW-1:0] cpu_addr,
    input wire upper_byte_strobe,
    input wire lower_byte_strobe,
    input wire rxdma_req,
    input wire [AW-1:0] rxdma_addr,
    input wire txdma_req,
    input wire [AW-1:0] txdma_addr,
    input wire intc_req,
    input wire [AW-1:0] intc_addr,
    output reg [4:0] grant_r,
    output reg [4:0] done_r,
    input wire token_input,
    output reg token_output,
    output reg busy_r,
    output reg [18:0] memory_address_line,
    output reg [7:0] byte_chip_enable_n,
    output reg [3:0] row_strobe_n,
    output reg [1:0] column_strobe_n
);
    // ==========================================================
    // Constants
    localparam [31:0] TOK_CYC_RAW = (`SMI_TOKEN_NS + CLK_NS - 1) / CLK_NS;
    localparam [3:0] TOK_CYC = (TOK_CYC_RAW < 1) ? 4'h1 : TOK_CYC_RAW[3:0];
    localparam ST_IDLE = 2'h0;
    localparam ST_ROW = 2'h1;
    localparam ST_COL = 2'h2;
    localparam ST_END = 2'h3;

    // ==========================================================
    // Registers and input synchronisers
    reg [15:0] cfg_r;
    reg [1:0] state_r;
    reg [3:0] cnt_r;
    reg [AW-1:0] addr_r;
    reg [1:0] bytes_r;
    reg refcyc_r;
    reg [7:0] ref_div_r;
    reg [7:0] ref_cnt_r;
    reg ref_pend_r;
    reg [10:0] ref_row_r;
    reg [2:0] tok_sync_r;
    reg have_token_r;
    reg [3:0] tok_cnt_r;
    reg [2:0] cpu_sync_r;
    reg cpu_lvl_r;
    reg cpu_hold_r;
    wire cpu_agree = (cpu_sync_r[1] == cpu_sync_r[2]);
    wire [4:0] grant;
    wire [2:0] org = cfg_r[`SMI_CFG_ORG_HI:`SMI_CFG_ORG_LO];
    wire [3:0] p_cyc = cfg_r[`SMI_CFG_P_HI:`SMI_CFG_P_LO];
    wire is_dram = (org == `SMI_ORG_D256) || (org == `SMI_ORG_D1M) ||
        (org == `SMI_ORG_D4M);

    // Register port: memory_cycle_config write and read back
    always @(posedge ref_clk)
    begin
        if (reset)
            cfg_r <= `SMI_CFG_RESET;
        else if (register_select && reg_wr && reg_addr == `SMI_CFG_OFFSET)
            cfg_r <= reg_wdata;
    end
    always @(posedge ref_clk)
    begin
        if (reset)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= (register_select && reg_addr == `SMI_CFG_OFFSET) ?
                cfg_r : 16'h0000;
    end

    // Pins through three flops; a settled select rise asks for one cycle
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            tok_sync_r <= 3'h0;
            cpu_sync_r <= 3'h0;
            cpu_lvl_r <= 1'b0;
            cpu_hold_r <= 1'b0;
        end
        else
        begin
            tok_sync_r <= {tok_sync_r[1:0], token_input};
            cpu_sync_r <= {cpu_sync_r[1:0], shared_memory_select};
            if (cpu_agree)
                cpu_lvl_r <= cpu_sync_r[2];
            if (cpu_agree && cpu_sync_r[2] && !cpu_lvl_r)
                cpu_hold_r <= 1'b1; // [R15]
            else if (grant[`SMI_REQ_CPU])
                cpu_hold_r <= 1'b0;
        end
    end
    wire tok_rise = tok_sync_r[1] & tok_sync_r[2] & ~have_token_r &
        (tok_cnt_r == 4'h0);

    // ==========================================================
    // Refresh timer
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            ref_div_r <= 8'h00;
            ref_cnt_r <= 8'h00;
            ref_pend_r <= 1'b0;
        end
        else
        begin
            ref_div_r <= (ref_div_r == `SMI_REF_UNIT) ? 8'h00 :
                ref_div_r + 8'h01;
            if ((refcyc_r && state_r == ST_END) || !is_dram)
                ref_pend_r <= 1'b0;
            if (is_dram && ref_div_r == `SMI_REF_UNIT)
            begin
                if (ref_cnt_r >= cfg_r[`SMI_CFG_REF_HI:`SMI_CFG_REF_LO])
                begin
                    ref_cnt_r <= 8'h00;
                    ref_pend_r <= 1'b1; // [R9]
                end
                else
                    ref_cnt_r <= ref_cnt_r + 8'h01;
            end
        end
    end

    // ==========================================================
    // Arbitration
    wire [4:0] reqs = {ref_pend_r, intc_req, txdma_req, cpu_hold_r, rxdma_req};
    smi_arbiter #(.N(`SMI_NREQ)) u_arb (
        .req(reqs),
        .enable(state_r == ST_IDLE && have_token_r), // [R16]
        .grant(grant)
    );
    // Address of the winning requester
    wire [AW-1:0] sel_addr = grant[`SMI_REQ_RXDMA] ? rxdma_addr :
        grant[`SMI_REQ_CPU] ? cpu_addr :
        grant[`SMI_REQ_TXDMA] ? txdma_addr :
        grant[`SMI_REQ_INTC] ? intc_addr : {AW{1'b0}};

    // ==========================================================
    // Address decode
    reg [7:0] ce_dec;
    reg [3:0] ras_dec;
    reg [18:0] row_a;
    reg [18:0] col_a;
    // Byte enables, row strobe and multiplexed address per organisation
    always @*
    begin
        ce_dec = 8'hff;
        ras_dec = 4'hf;
        row_a = 19'h00000;
        col_a = 19'h00000;
        case (org)
            `SMI_ORG_S128:
            begin
                ce_dec[{addr_r[19], addr_r[18], addr_r[0]}] = 1'b0; // [R5]
                row_a = {2'h0, addr_r[17:1]}; // [R6]
            end
            `SMI_ORG_S512:
            begin
                ce_dec[addr_r[0]] = 1'b0; // [R7]
                row_a = addr_r[19:1]; // [R4] [R1]
            end
            `SMI_ORG_D256:
            begin
                ras_dec[{addr_r[20], addr_r[19]}] = 1'b0; // [R10]
                row_a = {10'h000, addr_r[18:10]};
                col_a = {10'h000, addr_r[9:1]};
            end
            `SMI_ORG_D1M:
            begin
                ras_dec[{addr_r[22], addr_r[20]}] = 1'b0; // [R11]
                row_a = {9'h000, addr_r[20:11]};
                col_a = {9'h000, addr_r[10:1]};
            end
            `SMI_ORG_D4M:
            begin
                ras_dec[{1'b0, addr_r[23]}] = 1'b0; // [R12] [R1]
                row_a = {8'h00, addr_r[22:12]}; // [R8]
                col_a = {8'h00, addr_r[11:1]};
            end
            default: ce_dec = 8'hff;
        endcase
    end

    // ==========================================================
    // Memory cycle sequencer, p crystal periods per phase
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            addr_r <= {AW{1'b0}};
            bytes_r <= 2'h0;
            refcyc_r <= 1'b0;
            busy_r <= 1'b0;
            grant_r <= 5'h00;
            done_r <= 5'h00;
            ref_row_r <= 11'h000;
            memory_address_line <= 19'h00000;
            byte_chip_enable_n <= 8'hff;
            row_strobe_n <= 4'hf;
            column_strobe_n <= 2'h3;
        end
        else
        begin
            done_r <= 5'h00;
            case (state_r)
                ST_IDLE:
                begin
                    byte_chip_enable_n <= 8'hff; // [R17]
                    row_strobe_n <= 4'hf;
                    column_strobe_n <= 2'h3;
                    if (grant != 5'h00)
                    begin
                        grant_r <= grant;
                        addr_r <= sel_addr;
                        // Word access unless a single byte strobe
                        bytes_r <= (grant[`SMI_REQ_CPU] &&
                            (upper_byte_strobe ^ lower_byte_strobe)) ?
                            {upper_byte_strobe, lower_byte_strobe} :
                            2'h3; // [R2]
                        refcyc_r <= grant[`SMI_REQ_REFR];
                        busy_r <= 1'b1;
                        cnt_r <= 4'h0;
                        state_r <= ST_ROW;
                    end
                end
                ST_ROW:
                begin
                    memory_address_line <= refcyc_r ?
                        {8'h00, ref_row_r} : row_a;
                    if (refcyc_r)
                        row_strobe_n <= 4'h0; // [R9]
                    else if (is_dram)
                        row_strobe_n <= ras_dec;
                    else
                        byte_chip_enable_n <= ce_dec;
                    cnt_r <= (cnt_r + 4'h1 >= p_cyc) ? 4'h0 : cnt_r + 4'h1;
                    if (cnt_r + 4'h1 >= p_cyc) // [R3]
                        state_r <= ST_COL;
                end
                ST_COL:
                begin
                    if (is_dram && !refcyc_r)
                    begin
                        memory_address_line <= col_a;
                        column_strobe_n <= ~bytes_r; // [R8]
                    end
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r + 4'h1 >= p_cyc) // [R3]
                        state_r <= ST_END;
                end
                default:
                begin
                    byte_chip_enable_n <= 8'hff; // [R17]
                    row_strobe_n <= 4'hf;
                    column_strobe_n <= 2'h3;
                    if (refcyc_r)
                        ref_row_r <= ref_row_r + 11'h001;
                    done_r <= grant_r;
                    grant_r <= 5'h00;
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Token ring: hold token, pass when idle with no requests
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            have_token_r <= 1'b0;
            tok_cnt_r <= 4'h0;
            token_output <= 1'b0;
        end
        else
        begin
            if (tok_rise)
                have_token_r <= 1'b1; // [R16]
            else if (have_token_r && state_r == ST_IDLE && reqs == 5'h00)
            begin
                have_token_r <= 1'b0; // [R16]
                tok_cnt_r <= TOK_CYC;
                token_output <= 1'b1; // [R14]
            end
            else if (tok_cnt_r != 4'h0)
            begin
                tok_cnt_r <= tok_cnt_r - 4'h1;
                if (tok_cnt_r == 4'h1)
                    token_output <= 1'b0; // [R14]
            end
        end
    end
endmodule
`default_nettype wire

// file: include/smi_defs.vh
// Constants for the shared memory interface
`ifndef SMI_DEFS_VH
`define SMI_DEFS_VH
// Register offset and field layout of memory_cycle_config
`define SMI_CFG_OFFSET 8'h32
`define SMI_CFG_RESET 16'h0044
`define SMI_CFG_P_LO 0
`define SMI_CFG_P_HI 3
`define SMI_CFG_ORG_LO 4
`define SMI_CFG_ORG_HI 6
`define SMI_CFG_REF_LO 8
`define SMI_CFG_REF_HI 15
// Memory organisations
`define SMI_ORG_S128 3'h0
`define SMI_ORG_S512 3'h1
`define SMI_ORG_D256 3'h2
`define SMI_ORG_D1M 3'h3
`define SMI_ORG_D4M 3'h4
// Requesters, index is priority (0 highest)
`define SMI_REQ_RXDMA 0
`define SMI_REQ_CPU 1
`define SMI_REQ_TXDMA 2
`define SMI_REQ_INTC 3
`define SMI_REQ_REFR 4
`define SMI_NREQ 5
// Token pulse
`define SMI_TOKEN_NS 30
`define SMI_CLK_PERIOD_NS 10
// Refresh interval unit: last count of a ref_clk divider from 0 (one unit is 17 cycles)
`define SMI_REF_UNIT 8'h10
`endif

// file: hdl/smi_arbiter.v
// Fixed-priority arbiter for shared memory requesters
`timescale 1ns/1ps
`default_nettype none
`include "smi_defs.vh"
module smi_arbiter #(
    parameter N = `SMI_NREQ
) (
    input wire [N-1:0] req,
    input wire enable,
    output reg [N-1:0] grant
);
    integer i;
    reg found;
    // Lowest index wins
    always @*
    begin
        grant = {N{1'b0}};
        found = 1'b0;
        for (i = 0; i < N; i = i + 1)
        begin
            if (enable && req[i] && !found)
            begin
                grant[i] = 1'b1; // [R13]
                found = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/smi_mem_if_chk.sv
// Checker watching the shared memory interface ports
`timescale 1ns/1ps
`default_nettype none
`include "smi_defs.vh"
module smi_mem_if_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic register_select,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [4:0] grant_r,
    input wire logic [4:0] done_r,
    input wire logic token_output,
    input wire logic busy_r,
    input wire logic [7:0] byte_chip_enable_n,
    input wire logic [3:0] row_strobe_n,
    input wire logic [1:0] column_strobe_n
);
    localparam logic [15:0] CFG_RST = `SMI_CFG_RESET;
    logic [3:0] p_r;
    logic [5:0] cnt_r;
    logic [5:0] len_w;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // ======
    // Shadow of the phase length and a busy cycle count
    always @(posedge ref_clk)
    begin
        if (reset)
            p_r <= CFG_RST[3:0];
        else if (register_select && reg_wr && reg_addr == `SMI_CFG_OFFSET)
            p_r <= reg_wdata[3:0];
        cnt_r <= busy_r ? cnt_r + 6'h01 : 6'h00;
    end
    // Busy length is two phases plus one, zero phase taken as one
    assign len_w = {1'b0, (p_r == 4'h0) ? 4'h1 : p_r, 1'b1};
    // ======
    // Assertions
    idle_strobes_a: assert property (!busy_r |-> &byte_chip_enable_n
        && &row_strobe_n && &column_strobe_n) else $error("strobe low idle");
    one_grant_a: assert property ($onehot0(grant_r))
        else $error("two grants at once");
    cycle_len_a: assert property (|done_r[3:0] |-> cnt_r == len_w)
        else $error("cycle length wrong");
    done_pulse_a: assert property (|done_r |=> done_r == 5'h00)
        else $error("done longer than one cycle");
    grant_done_a: assert property (|done_r |-> done_r == $past(grant_r))
        else $error("done not of granted unit");
    token_pulse_a: assert property ($rose(token_output) |->
        token_output [*3] ##1 !token_output) else $error("token pulse length");
    token_free_a: assert property (token_output |-> !busy_r
        && grant_r == 5'h00) else $error("token passed while busy");
    refresh_cas_a: assert property (grant_r[4] |->
        column_strobe_n == 2'b11) else $error("column strobe in refresh");
    cover property (done_r[1]);
    cover property (grant_r[4]);
    cover property ($rose(token_output));
endmodule
bind smi_mem_if smi_mem_if_chk i_smi_mem_if_chk (.ref_clk, .reset,
    .register_select, .reg_wr, .reg_addr, .reg_wdata, .grant_r, .done_r,
    .token_output, .busy_r, .byte_chip_enable_n, .row_strobe_n,
    .column_strobe_n);
`default_nettype wire

// file: test/smi_mem_model.sv
// Memory chip model recording what each strobe selects
`timescale 1ns/1ps
`default_nettype none
module smi_mem_model (
    input wire logic ref_clk,
    input wire logic [18:0] memory_address_line,
    input wire logic [7:0] byte_chip_enable_n,
    input wire logic [3:0] row_strobe_n,
    input wire logic [1:0] column_strobe_n,
    output logic [7:0] ce_q,
    output logic [3:0] ras_q,
    output logic [1:0] cas_q,
    output logic [18:0] adr_q,
    output logic [10:0] col_q,
    output logic [7:0] ref_q
);
    logic [13:0] prev_r = 14'h3fff;
    initial ref_q = 8'h00;
    // ======
    // Latch enables, strobes and address when a strobe first goes low
    always @(posedge ref_clk)
    begin
        prev_r <= {byte_chip_enable_n, row_strobe_n, column_strobe_n};
        if (&prev_r[13:6] && !(&byte_chip_enable_n))
            {ce_q, adr_q} <= {byte_chip_enable_n, memory_address_line};
        if (&prev_r[5:2] && row_strobe_n == 4'h0)
            ref_q <= ref_q + 8'h01; // Refresh, all banks at once
        else if (&prev_r[5:2] && !(&row_strobe_n))
            {ras_q, adr_q} <= {row_strobe_n, memory_address_line};
        if (&prev_r[1:0] && !(&column_strobe_n))
            {cas_q, col_q} <= {column_strobe_n, memory_address_line[10:0]};
    end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the shared memory interface
`timescale 1ns/1ps
`default_nettype none
`include "smi_defs.vh"
module tb;
    logic ref_clk, reset, register_select, reg_wr, token_input;
    logic upper_byte_strobe, lower_byte_strobe, token_output, busy_r;
    logic shared_memory_select, rxdma_req, txdma_req, intc_req;
    logic [3:0] rq, row_strobe_n, ras_q;
    logic [7:0] reg_addr, byte_chip_enable_n, ce_q, ref_q;
    logic [15:0] reg_wdata, reg_rdata;
    logic [23:0] cpu_addr;
    logic [4:0] grant_r, done_r;
    logic [18:0] memory_address_line, adr_q;
    logic [1:0] column_strobe_n, cas_q;
    logic [10:0] col_q;
    int n_fail = 0;
    int n_checks = 0;
    // ======
    // Design, memory model and request wiring
    assign {intc_req, txdma_req, shared_memory_select, rxdma_req} = rq;
    smi_mem_if i_smi_mem_if (.ref_clk, .reset, .register_select, .reg_wr,
        .reg_addr, .reg_wdata, .reg_rdata, .shared_memory_select, .cpu_addr,
        .upper_byte_strobe, .lower_byte_strobe, .rxdma_req, .txdma_req,
        .rxdma_addr(24'h000100), .txdma_addr(24'h000200), .intc_req,
        .intc_addr(24'h000300), .grant_r, .done_r, .token_input,
        .token_output, .busy_r, .memory_address_line, .byte_chip_enable_n,
        .row_strobe_n, .column_strobe_n);
    smi_mem_model i_smi_mem_model (.ref_clk, .memory_address_line,
        .byte_chip_enable_n, .row_strobe_n, .column_strobe_n, .ce_q, .ras_q,
        .cas_q, .adr_q, .col_q, .ref_q);
    // Clock at 100 MHz
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ======
    // Shared helpers
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wt(input logic [5:0] m);
        int i;
        for (i = 0; i < 300 && ({token_output, done_r} & m) == 6'h00; i++)
            @(negedge ref_clk);
        if (i == 300)
        begin
            chk("wait", 0, m);
            close_out;
        end
    endtask
    task automatic reg_acc(input logic wr, input logic [7:0] a,
        input logic [15:0] d);
        @(negedge ref_clk);
        {register_select, reg_wr, reg_addr, reg_wdata} = {1'b1, wr, a, d};
        @(negedge ref_clk);
        {register_select, reg_wr} = 2'b00;
    endtask
    task automatic tok;
        @(negedge ref_clk);
        token_input = 1'b1;
        repeat (3) @(negedge ref_clk);
        token_input = 1'b0;
    endtask
    // ======
    // Scenarios
    task automatic t_regs;
        reg_acc(0, `SMI_CFG_OFFSET, 16'h0000);
        chk("cfg reset", reg_rdata, `SMI_CFG_RESET);
        reg_acc(0, 8'h30, 16'h0000);
        chk("unmapped", reg_rdata, 0);
        $display("test regs done");
    endtask
    task automatic t_prio;
        int k;
        rq = 4'h1;
        repeat (40) @(negedge ref_clk);
        chk("no token grant", grant_r, 0);
        {upper_byte_strobe, lower_byte_strobe, cpu_addr} = {2'b11, 24'h10};
        rq = 4'hf; // Memory through the second select
        repeat (4) @(negedge ref_clk);
        tok;
        for (k = 0; k < 4; k++)
        begin
            wt(6'h0f);
            chk("done order", done_r, 32'h1 << k);
            rq[k] = 1'b0;
            @(negedge ref_clk);
        end
        wt(6'h20);
        chk("busy at token", busy_r, 0);
        $display("test prio done");
    endtask
    task automatic t_map;
        int k;
        int nb;
        logic [23:0] a;
        logic [7:0] sel;
        logic [31:0] e, m, s;
        for (k = 0; k < 5; k++)
        begin
            case (k)
                0: {a, sel} = {24'h0d5a5b, 8'h7f};
                1: {a, sel} = {24'h0a5a5a, 8'hfe};
                2: {a, sel} = {24'h1a5a5b, 8'h1d};
                3: {a, sel} = {24'h4a5a5a, 8'h2e};
                default: {a, sel} = {24'ha5a5a4, 8'h34};
            endcase
            nb = (k < 2) ? 17 + 2 * k : k + 7;
            m = (32'h1 << nb) - 32'h1;
            e = (a >> 1) & ((32'h1 << (k < 2 ? nb : 2 * nb)) - 32'h1);
            // Loop index doubles as the organisation code
            reg_acc(1, `SMI_CFG_OFFSET, {9'h000, k[2:0], 4'h2});
            reg_acc(0, `SMI_CFG_OFFSET, 16'h0000);
            chk("cfg rw", reg_rdata, {9'h000, k[2:0], 4'h2});
            cpu_addr = a;
            {upper_byte_strobe, lower_byte_strobe} = {a[0] | k == 4,
                !a[0] | k == 4};
            rq[1] = 1'b1;
            repeat (4) @(negedge ref_clk);
            tok;
            wt(6'h02);
            rq[1] = 1'b0;
            wt(6'h20);
            repeat (4) @(negedge ref_clk);
            if (k < 2)
            begin
                chk("enable", ce_q, sel);
                chk("sram adr", adr_q & m, e);
            end
            else
            begin
                chk("ras cas", {ras_q, cas_q}, sel);
                s = ((adr_q & m) << nb) | (col_q & m);
                chk("dram adr", s, e);
            end
        end
        $display("test map done");
    endtask
    task automatic t_ref;
        logic [7:0] r0;
        reg_acc(1, `SMI_CFG_OFFSET, 16'h0142);
        r0 = ref_q;
        repeat (5)
        begin
            tok;
            repeat (40) @(negedge ref_clk);
        end
        chk("refresh", ref_q != r0, 1);
        $display("test refresh done");
    endtask
    // ======
    // Main sequence
    initial
    begin
        {reset, register_select, reg_wr, token_input} = 4'h8;
        {upper_byte_strobe, lower_byte_strobe, rq} = 6'h00;
        {reg_addr, reg_wdata, cpu_addr} = 48'h0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        t_regs;
        t_prio;
        t_map;
        t_ref;
        close_out;
    end
endmodule
`default_nettype wire
